// *** core/twm_mode_ctrl.sv ***
// Mode register of a two-wire serial controller with a small frame engine.
// Assumes an Avalon-MM master on i_ref_clk and open-drain pads outside.
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module twm_mode_ctrl
  import twm_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input twm_av_req_s i_av,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_scl,
  output logic o_scl_out,
  output logic o_scl_oe_n,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  output logic o_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic wait_r;
  logic [31:0] rdata_r;
  logic order_r, delay_r, fmt_r, mst_r, ack_r;
  logic [2:0] cnt_r;
  logic [7:0] tx_r, txs_r, rxs_r;
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2;
  twm_state_e st_r;
  logic [8:0] tmr_r;
  logic [3:0] left_r, frame_len;
  logic wr, wr_mode, go, busy, twowire, ack_bit, cur_bit;
  logic rise_ev, fall_ev, frame_end, stretch_go;
  logic [7:0] mode_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; a request is taken on the edge where waitrequest is low
  assign wr = i_av.write && !wait_r;
  assign wr_mode = wr && (i_av.address == OFS_MODE);
  assign go = wr && (i_av.address == OFS_CTRL) && i_av.writedata[B_GO] && !busy;
  assign busy = (st_r != ST_IDLE);
  assign twowire = !fmt_r;
  // Ack is the last bit of a two-wire frame
  assign ack_bit = twowire && (left_r == 4'h1);
  assign cur_bit = order_r ? txs_r[0] : txs_r[7];
  // Code 000 is the full frame; two-wire adds one ack bit
  assign frame_len = ((cnt_r == 3'h0) ? 4'h8 : {1'b0, cnt_r}) + {3'h0, twowire};
  // Count field shows the low three bits of what is left while a frame runs
  assign mode_rd = {order_r, delay_r, RSV_ONES, 1'b1, busy ? left_r[2:0] : cnt_r};

  ////////////////////////////////////////////////////////////////////////////
  // Avalon handshake: one wait cycle, read data latched when request seen
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else if ((i_av.read || i_av.write) && wait_r) begin
      wait_r <= 1'b0;
      case (i_av.address)
        OFS_MODE: rdata_r <= {24'h00_0000, mode_rd};
        OFS_CTRL: rdata_r <= {30'h0000_0000, mst_r, fmt_r};
        OFS_DATA: rdata_r <= {24'h00_0000, rxs_r};
        OFS_STAT: rdata_r <= {30'h0000_0000, ack_r, busy};
        default: rdata_r <= 32'h0000_0000; // Unmapped reads as zero
      endcase
    end else begin
      wait_r <= 1'b1;
    end
  end

  assign o_readdata = rdata_r;
  assign o_waitrequest = wait_r;

  ////////////////////////////////////////////////////////////////////////////
  // Mode register; a guarded write leaves the count alone
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      order_r <= RST_ORDER;
      delay_r <= RST_DELAY;
      cnt_r <= RST_CNT;
    end else begin
      if (frame_end) begin
        cnt_r <= 3'h0;
      end
      if (wr_mode) begin
        order_r <= i_av.writedata[B_ORDER];
        delay_r <= i_av.writedata[B_DELAY];
        // Write beats frame end so a fresh count is not lost
        if (!i_av.writedata[B_GUARD]) begin
          cnt_r <= i_av.writedata[2:0];
        end
      end
    end
  end

  // Control and transmit data
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      fmt_r <= RST_FMT;
      mst_r <= RST_MST;
      tx_r <= RST_TX;
    end else if (wr) begin
      if (i_av.address == OFS_CTRL && !busy) begin
        fmt_r <= i_av.writedata[B_FMT];
        mst_r <= i_av.writedata[B_MST];
      end
      if (i_av.address == OFS_DATA) begin
        tx_r <= i_av.writedata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; scl_d trails the second stage for edge detection
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      scl_s1 <= i_scl;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= i_sda;
      sda_s2 <= sda_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit timing: master paces itself, slave follows the line clock
  assign rise_ev = (st_r == ST_LOW) && (mst_r ? (tmr_r == 9'h000) : (scl_s2 && !scl_d));
  assign fall_ev = (st_r == ST_HIGH) && (mst_r ? (tmr_r == 9'h000) : (!scl_s2 && scl_d));
  assign frame_end = fall_ev && (left_r == 4'h1);
  // Only a two-wire master stretches, and only before the ack bit
  assign stretch_go = mst_r && twowire && delay_r && (left_r == 4'h2);

  // Frame engine
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= ST_IDLE;
      tmr_r <= 9'h000;
      left_r <= 4'h0;
      txs_r <= 8'h00;
      rxs_r <= 8'h00;
      ack_r <= 1'b0;
    end else begin
      if (tmr_r != 9'h000) begin
        tmr_r <= tmr_r - 9'h001;
      end
      case (st_r)
        ST_IDLE: begin
          if (go) begin
            st_r <= ST_LOW;
            tmr_r <= HALF_LD;
            left_r <= frame_len;
            txs_r <= tx_r;
          end
        end
        ST_LOW: begin
          if (rise_ev) begin
            st_r <= ST_HIGH;
            tmr_r <= HALF_LD;
            if (ack_bit) begin
              ack_r <= sda_s2;
            end else if (order_r) begin
              rxs_r <= {sda_s2, rxs_r[7:1]};
            end else begin
              rxs_r <= {rxs_r[6:0], sda_s2};
            end
          end
        end
        ST_HIGH: begin
          if (fall_ev) begin
            left_r <= left_r - 4'h1;
            txs_r <= order_r ? {1'b0, txs_r[7:1]} : {txs_r[6:0], 1'b0};
            if (left_r == 4'h1) begin
              st_r <= ST_IDLE;
            end else if (stretch_go) begin
              st_r <= ST_STRETCH;
              tmr_r <= STRETCH_LD;
            end else begin
              st_r <= ST_LOW;
              tmr_r <= HALF_LD;
            end
          end
        end
        ST_STRETCH: begin
          if (tmr_r == 9'h000) begin
            st_r <= ST_LOW;
            tmr_r <= HALF_LD;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive: enables are registered, so pins lag the state by one cycle
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_scl_out <= 1'b0;
      o_scl_oe_n <= 1'b1;
      o_sda_out <= 1'b0;
      o_sda_oe_n <= 1'b1;
      o_busy <= 1'b0;
    end else begin
      o_scl_out <= 1'b0; // Open drain: only ever pulls low
      o_sda_out <= 1'b0;
      o_scl_oe_n <= !(mst_r && ((st_r == ST_LOW) || (st_r == ST_STRETCH)));
      // Release data during the ack bit so the receiver can answer
      o_sda_oe_n <= (busy && !ack_bit) ? cur_bit : 1'b1;
      o_busy <= busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [8:0] sc_r;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sc_r <= 9'h000;
    end else begin
      sc_r <= (st_r == ST_STRETCH) ? sc_r + 9'h001 : 9'h000;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_order_drive: assert property ((busy && !ack_bit) |=> (o_sda_oe_n == $past(cur_bit)))
    else $error("data pin does not follow selected bit order");
  a_stretch_len: assert property ((st_r == ST_STRETCH && tmr_r == 9'h000) |-> (sc_r == STRETCH_LD))
    else $error("clock stretch length wrong");
  a_stretch_low: assert property ((st_r == ST_STRETCH) |=> !o_scl_oe_n)
    else $error("clock not held low during stretch");
  a_no_delay: assert property ((fall_ev && left_r == 4'h2 && !delay_r) |=> (st_r == ST_LOW))
    else $error("delay inserted with delay field clear");
  a_stretch_scope: assert property ((st_r == ST_STRETCH) |-> (mst_r && twowire))
    else $error("stretch outside two-wire master mode");
  a_reserved_ones: assert property ((i_av.read && wait_r && i_av.address == OFS_MODE)
    |=> (o_readdata[5:3] == 3'h7))
    else $error("reserved or guard bits not read as one");
  a_count_load: assert property ((wr_mode && !i_av.writedata[B_GUARD]) |=> (cnt_r == $past(i_av.writedata[2:0])))
    else $error("unguarded write did not load count");
  a_count_keep: assert property ((wr_mode && i_av.writedata[B_GUARD] && !frame_end) |=> $stable(cnt_r))
    else $error("guarded write changed count");
  a_frame_len: assert property (go |=> (left_r == $past(frame_len)) && busy ##1 busy)
    else $error("frame length not loaded from count");
  a_count_read: assert property ((i_av.read && wait_r && i_av.address == OFS_MODE && busy)
    |=> (o_readdata[2:0] == $past(left_r[2:0])))
    else $error("count read does not show bits left");
  a_count_clear: assert property ((frame_end && !wr_mode) |=> (cnt_r == 3'h0) && !busy)
    else $error("count not cleared at frame end");

  c_stretch: cover property ((st_r == ST_STRETCH) ##1 (st_r == ST_LOW));
  c_lsb_frame: cover property (frame_end && order_r);
  c_slave_frame: cover property (frame_end && !mst_r);
  c_sync_frame: cover property (frame_end && fmt_r && mst_r);

endmodule : twm_mode_ctrl

// *** core/twm_pkg.sv ***
// Constants and types of the two-wire mode register block.
// Assumes a 20 MHz reference clock and a 32-bit Avalon-MM register bus.
package twm_pkg;

  // Clock and transfer-clock timing
  localparam int CLK_NS = 50;
  localparam int HALF_NS = 2500; // Half transfer-clock period in ns
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int STRETCH_CYC = 4 * HALF_CYC; // Two whole transfer clocks
  localparam logic [8:0] HALF_LD = 9'(HALF_CYC - 1);
  localparam logic [8:0] STRETCH_LD = 9'(STRETCH_CYC - 1);

  // Register byte offsets
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hC;

  // Field positions
  localparam int B_ORDER = 7;
  localparam int B_DELAY = 6;
  localparam int B_GUARD = 3;
  localparam int B_FMT = 0; // Control: 1 = clock-synchronous format
  localparam int B_MST = 1; // Control: 1 = master
  localparam int B_GO = 2; // Control: write 1 to start a frame

  // Values after reset
  localparam logic RST_ORDER = 1'b0;
  localparam logic RST_DELAY = 1'b0;
  localparam logic [2:0] RST_CNT = 3'h0;
  localparam logic RST_FMT = 1'b0;
  localparam logic RST_MST = 1'b0;
  localparam logic [7:0] RST_TX = 8'h00;
  localparam logic [1:0] RSV_ONES = 2'h3;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } twm_av_req_s;

  typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_STRETCH} twm_state_e;

endpackage : twm_pkg

// *** tb/twm_bus_model.sv ***
// Far-side devices on the two-wire lines: pull-ups, a listener and an acknowledger.
// Assumes the open-drain enables of the mode block; the listener never drives the clock.
`timescale 1ns/1ps
module twm_bus_model (
  input wire logic i_ref_clk,
  input wire logic i_clr,
  input wire logic i_scl_oe_n,
  input wire logic i_sda_oe_n,
  input wire logic [3:0] i_ack_pos,
  output logic o_scl,
  output logic o_sda,
  output logic [3:0] o_nbits,
  output logic [15:0] o_shift,
  output logic [9:0] o_max_low
);
  logic [9:0] low_run_r;
  // Wired-AND with pull-ups; the ack is pulled low from the previous clock rise until the ack clock rise
  assign o_scl = i_scl_oe_n;
  assign o_sda = i_sda_oe_n & (o_nbits != i_ack_pos);
  ////////////////////////////////////////////////////////////////////////
  // Bits are taken at the clock rise, as a real receiver would
  always @(posedge o_scl or posedge i_clr) begin
    if (i_clr) begin
      o_nbits <= 4'h0;
      o_shift <= 16'h0000;
    end else begin
      o_nbits <= o_nbits + 4'h1;
      o_shift <= {o_shift[14:0], o_sda};
    end
  end
  // Longest clock-low run, to see any stretch before the ack
  always @(posedge i_ref_clk) begin
    if (i_clr) begin
      low_run_r <= 10'h000;
      o_max_low <= 10'h000;
    end else begin
      low_run_r <= o_scl ? 10'h000 : low_run_r + 10'h001;
      if (low_run_r > o_max_low) o_max_low <= low_run_r;
    end
  end
endmodule : twm_bus_model

// *** tb/test_twowire_mode_register.sv ***
// Bench for the mode register: register checks, then frames in both formats.
// Assumes the bus model on the pins and Avalon-MM access at one wait cycle or more.
`timescale 1ns/1ps
module test_twowire_mode_register;
  import twm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clr = 1'b1;
  twm_av_req_s req = '0;
  logic [31:0] rdata;
  logic wreq, busy, scl_oe_n, sda_oe_n, scl, sda, s_out, d_out;
  logic [3:0] nbits;
  logic [3:0] ack_pos = 4'hF;
  logic [15:0] shift;
  logic [9:0] max_low;
  logic [31:0] q;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  localparam logic [7:0] MODE_V [4] = '{8'h00, 8'hC8, 8'h43, 8'h48};
  localparam logic [7:0] CTRL_V [4] = '{8'h02, 8'h03, 8'h02, 8'h03};
  localparam logic [7:0] TX_V [4] = '{8'hA5, 8'hC1, 8'hC1, 8'hC1};
  localparam logic [3:0] BITS_V [4] = '{4'h9, 4'h8, 4'h4, 4'h8};
  localparam logic [15:0] SH_V [4] = '{16'h014A, 16'h0083, 16'h000C, 16'h00C1};
  localparam logic [3:0] ACK_V [4] = '{4'h8, 4'hF, 4'h3, 4'hF};
  twm_mode_ctrl i_twm_mode_ctrl (.i_ref_clk(clk), .i_rst(rst), .i_av(req), .o_readdata(rdata),
    .o_waitrequest(wreq), .i_scl(scl), .o_scl_out(s_out), .o_scl_oe_n(scl_oe_n), .i_sda(sda),
    .o_sda_out(d_out), .o_sda_oe_n(sda_oe_n), .o_busy(busy));
  twm_bus_model i_twm_bus_model (.i_ref_clk(clk), .i_clr(clr), .i_scl_oe_n(scl_oe_n),
    .i_sda_oe_n(sda_oe_n), .i_ack_pos(ack_pos), .o_scl(scl), .o_sda(sda), .o_nbits(nbits),
    .o_shift(shift), .o_max_low(max_low));
  initial begin
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // Verdict; also reached from the hang guard
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One Avalon cycle; values read right after the edge are the ones sampled there
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req.read <= ~wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : av
  task automatic wait_busy(input logic lvl, input int lim);
    int k;
    for (k = 0; k < lim && busy !== lvl; k++) @(posedge clk);
  endtask : wait_busy
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int r;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    av(1'b0, OFS_MODE, 32'h0);
    check("mode reset", q, 32'h00000038);
    av(1'b1, OFS_MODE, 32'h0000007F);
    av(1'b0, OFS_MODE, 32'h0);
    check("guarded write", q, 32'h00000078);
    av(1'b1, OFS_MODE, 32'h00000005);
    av(1'b0, OFS_MODE, 32'h0);
    check("unguarded write", q, 32'h0000003D);
    av(1'b1, OFS_MODE, 32'h0000000A);
    av(1'b1, 4'h2, 32'h000000FF);
    av(1'b0, 4'h2, 32'h0);
    check("unmapped read", q, 32'h00000000);
    av(1'b0, OFS_MODE, 32'h0);
    check("count kept", q, 32'h0000003D);
    $display("register test done");
    for (r = 0; r < 4; r++) begin
      // Format first, then mode; the mode write sets bit order in either format, and count only when its guard bit is clear
      av(1'b1, OFS_CTRL, {24'h0, CTRL_V[r]});
      av(1'b1, OFS_MODE, {24'h0, MODE_V[r]});
      av(1'b1, OFS_DATA, {24'h0, TX_V[r]});
      ack_pos <= ACK_V[r];
      clr <= 1'b0;
      av(1'b1, OFS_CTRL, {24'h0, CTRL_V[r] | 8'h04});
      if (r == 0) begin
        av(1'b0, OFS_MODE, 32'h0);
        check("bits left", q, 32'h00000039);
      end
      wait_busy(1'b1, 10);
      wait_busy(1'b0, 3000);
      check("frame length", {28'h0, nbits}, {28'h0, BITS_V[r]});
      check("frame bits", {16'h0, shift & ((16'h1 << BITS_V[r]) - 16'h1)}, {16'h0, SH_V[r]});
      check("pad out levels", {30'h0, s_out, d_out}, 32'h0);
      if (r == 0) begin
        // Master samples its own data line; the far side pulled the ack low
        av(1'b0, OFS_DATA, 32'h0);
        check("received byte", q, 32'h000000A5);
        av(1'b0, OFS_STAT, 32'h0);
        check("ack and idle", q, 32'h00000000);
      end
      check("stretch", {31'h0, (r == 2) ? (max_low > 10'd239 && max_low < 10'd261)
        : (max_low > 10'd39 && max_low < 10'd61)}, 32'h1);
      av(1'b0, OFS_MODE, 32'h0);
      check("count cleared", q, {24'h0, (MODE_V[r] & 8'hC0) | 8'h38});
      clr <= 1'b1;
      $display("frame test %0d done", r);
    end
    complete_run();
  end
endmodule : test_twowire_mode_register
